// ### gpc_map.svh
// Address map, field masks, reset values and timing figures of the general-purpose port block.
`ifndef GPC_MAP_SVH
`define GPC_MAP_SVH

// ************************************************************
// Register addresses
// ************************************************************
`define GPC_ADDR_PORT2_DATA     16'hff02
`define GPC_ADDR_PORT3_DATA     16'hff03
`define GPC_ADDR_PORT4_DATA     16'hff04
`define GPC_ADDR_PORT2_DIR      16'hff22
`define GPC_ADDR_PORT3_DIR      16'hff23
`define GPC_ADDR_PORT4_DIR      16'hff24
`define GPC_ADDR_PORT2_PULLUP   16'hff32
`define GPC_ADDR_PORT3_PULLUP   16'hff33
`define GPC_ADDR_PORT4_PULLUP   16'hff34

// ************************************************************
// Implemented bits of each port
// ************************************************************
`define GPC_IMPL_PORT2          8'h0f
`define GPC_IMPL_PORT3          8'h04
`define GPC_IMPL_PORT4          8'hff
`define GPC_PORT3_IN_ONLY_MASK  8'h10
`define GPC_PORT3_IO_BIT        2
`define GPC_PORT3_IN_ONLY_BIT   4
`define GPC_PORT2_INT_BIT       1

// ************************************************************
// Reset values
// ************************************************************
`define GPC_RST_DATA            8'h00
`define GPC_RST_DIR             8'hff
`define GPC_RST_PULLUP          8'h00
`define GPC_RDATA_UNMAPPED      8'h00

// ************************************************************
// Timing
// ************************************************************
`define GPC_SYNC_STAGES         2

`endif

// ### gpc_pkg.sv
// Types shared by the general-purpose port block.
package gpc_pkg;

  // Index of a port inside the register arrays.
  typedef enum logic [1:0] {
    GPC_PORT2,
    GPC_PORT3,
    GPC_PORT4,
    GPC_PORT_NONE
  } gpc_port_t;

  // Kind of register addressed by the internal bus.
  typedef enum logic [1:0] {
    GPC_KIND_DATA,
    GPC_KIND_DIR,
    GPC_KIND_PULLUP,
    GPC_KIND_NONE
  } gpc_kind_t;

  // Sequence that decides the role of the shared reset pin.
  typedef enum logic [1:0] {
    GPC_RST_WAIT_PIN,
    GPC_RST_LOAD_OPTION,
    GPC_RST_RUN
  } gpc_rst_state_t;

endpackage : gpc_pkg

// ### gpc_sync.sv
// Two-stage synchroniser for pin levels entering the system clock domain.
`timescale 1ns/100ps
module gpc_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage1_d;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage2_d;

  always_comb
  begin
    stage1_d = asyncIn;
    stage2_d = stage1_q;
  end

  // The first stage feeds only the second; nothing else may look at it.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      stage1_q <= '0;
      stage2_q <= '0;
    end
    else
    begin
      stage1_q <= stage1_d;
      stage2_q <= stage2_d;
    end
  end

  assign syncOut = stage2_q;

endmodule : gpc_sync

// ### gpc_edge_detect.sv
// Edge detector that turns a synchronised pin level into one-cycle rise and fall pulses.
`timescale 1ns/100ps
module gpc_edge_detect (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic level,
  output logic      risePulse,
  output logic      fallPulse
);

  logic       last_q;
  logic       last_d;
  logic [1:0] armCnt_q;
  logic [1:0] armCnt_d;
  logic       armed;
  logic rise_q;
  logic rise_d;
  logic fall_q;
  logic fall_d;

  // The synchroniser in front shows its reset zero for two more edges, so pulses
  // stay masked until both samples hold the real pin level; otherwise a pin that
  // is already high would fake a rise just after reset.
  always_comb
  begin
    last_d   = level;
    armed    = (armCnt_q == 2'h3);
    armCnt_d = armed ? armCnt_q : armCnt_q + 2'h1;
    rise_d   = armed & level & ~last_q;
    fall_d   = armed & ~level & last_q;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      last_q   <= 1'b0;
      armCnt_q <= 2'h0;
      rise_q  <= 1'b0;
      fall_q  <= 1'b0;
    end
    else
    begin
      last_q   <= last_d;
      armCnt_q <= armCnt_d;
      rise_q  <= rise_d;
      fall_q  <= fall_d;
    end
  end

  assign risePulse = rise_q;
  assign fallPulse = fall_q;

endmodule : gpc_edge_detect

// ### gpc_port_ctrl.sv
// General-purpose port control for ports 2 to 4 with the shared reset pin on port 3.
`timescale 1ns/100ps
`include "gpc_map.svh"

// Notes on behaviour
// - Port 3 bit 2 bidirectional, direction bit selects
// - Port 3 bit 2 input pulls up when enabled
// - Port 3 bit 2 feeds external interrupt logic
// - Reset puts port 3 into input mode
// - Port 3 bit 4 input-only, reset at power-on
// - Option selects port or reset use
// - Option read after reset; low pin holds reset
// - Port 4 eight independent bidirectional pins
// - Port 4 input pins pull up per enable
// - Reset puts port 4 into input mode
// - Direction registers byte writable, reset all ones
// - Direction zero drives, one floats the pin
// - Driven level change on interrupt pin raises request
// - Data read: pin if input, latch if output
// - Latch value drives pin; input reads level
// - Data registers byte writable, reset to zero
// - Port 3 bit 4 read-only, follows pin
// - Pull-up registers byte writable, reset to zero
// - Pull-up bit one connects the resistor
// - Input-mode latch writes kept, pin undriven
// - Bit manipulation arrives as whole-byte access
module gpc_port_ctrl (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // Internal bus.
  input  wire logic [15:0] sfrAddr,
  input  wire logic        sfrWrite,
  input  wire logic        sfrRead,
  input  wire logic [7:0]  sfrWdata,
  output logic      [7:0]  sfrRdata,
  output logic             sfrRvalid,
  // Configuration byte bit: 1 selects port use of the shared reset pin.
  input  wire logic        optionPortSelect,
  // Port 2 pins.
  input  wire logic [3:0]  port2PinIn,
  output logic      [3:0]  port2PinOut,
  output logic      [3:0]  port2PinOe,
  output logic      [3:0]  port2PullupOn,
  // Port 3 bit 2 pin.
  input  wire logic        port3Bit2PinIn,
  output logic             port3Bit2PinOut,
  output logic             port3Bit2PinOe,
  output logic             port3Bit2PullupOn,
  // Port 3 bit 4 input-only pin, shared with the external reset.
  input  wire logic        port3Bit4InputPin,
  // Port 4 pins.
  input  wire logic [7:0]  port4PinIn,
  output logic      [7:0]  port4PinOut,
  output logic      [7:0]  port4PinOe,
  output logic      [7:0]  port4PullupOn,
  // Reset and interrupt outputs toward the rest of the chip.
  output logic             cpuResetHold,
  output logic             optionPortMode,
  output logic             port3Bit2IntRise,
  output logic             port3Bit2IntFall,
  output logic             port2Bit1IntRise,
  output logic             port2Bit1IntFall
);

  // ************************************************************
  // Decode helpers
  // ************************************************************

  function automatic gpc_pkg::gpc_port_t decodePort(input logic [15:0] addr);
    gpc_pkg::gpc_port_t port;
    port = gpc_pkg::GPC_PORT_NONE;
    if (addr == `GPC_ADDR_PORT2_DATA || addr == `GPC_ADDR_PORT2_DIR || addr == `GPC_ADDR_PORT2_PULLUP)
      port = gpc_pkg::GPC_PORT2;
    else if (addr == `GPC_ADDR_PORT3_DATA || addr == `GPC_ADDR_PORT3_DIR || addr == `GPC_ADDR_PORT3_PULLUP)
      port = gpc_pkg::GPC_PORT3;
    else if (addr == `GPC_ADDR_PORT4_DATA || addr == `GPC_ADDR_PORT4_DIR || addr == `GPC_ADDR_PORT4_PULLUP)
      port = gpc_pkg::GPC_PORT4;
    return port;
  endfunction : decodePort

  function automatic gpc_pkg::gpc_kind_t decodeKind(input logic [15:0] addr);
    gpc_pkg::gpc_kind_t kind;
    kind = gpc_pkg::GPC_KIND_NONE;
    if (addr == `GPC_ADDR_PORT2_DATA || addr == `GPC_ADDR_PORT3_DATA || addr == `GPC_ADDR_PORT4_DATA)
      kind = gpc_pkg::GPC_KIND_DATA;
    else if (addr == `GPC_ADDR_PORT2_DIR || addr == `GPC_ADDR_PORT3_DIR || addr == `GPC_ADDR_PORT4_DIR)
      kind = gpc_pkg::GPC_KIND_DIR;
    else if (addr == `GPC_ADDR_PORT2_PULLUP || addr == `GPC_ADDR_PORT3_PULLUP || addr == `GPC_ADDR_PORT4_PULLUP)
      kind = gpc_pkg::GPC_KIND_PULLUP;
    return kind;
  endfunction : decodeKind

  // ************************************************************
  // Pin synchronisation
  // ************************************************************

  localparam int NPORTS = 3;

  logic [7:0] implMask [NPORTS];
  logic [7:0] pinRaw   [NPORTS];
  logic [7:0] pinSync  [NPORTS];
  logic       resetPinSync;

  assign implMask[0] = `GPC_IMPL_PORT2;
  assign implMask[1] = `GPC_IMPL_PORT3;
  assign implMask[2] = `GPC_IMPL_PORT4;

  // Bit 4 of port 3 is carried in the port 3 lane so it shares the synchroniser.
  assign pinRaw[0] = {4'h0, port2PinIn};
  assign pinRaw[1] = {3'h0, port3Bit4InputPin, 1'b0, port3Bit2PinIn, 2'h0};
  assign pinRaw[2] = port4PinIn;

  genvar gp;
  generate
    for (gp = 0; gp < NPORTS; gp++)
    begin : g_sync
      gpc_sync #(
        .WIDTH (8)
      ) u_sync (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .asyncIn (pinRaw[gp]),
        .syncOut (pinSync[gp])
      );
    end
  endgenerate

  assign resetPinSync = pinSync[1][`GPC_PORT3_IN_ONLY_BIT];

  // ************************************************************
  // Port registers
  // ************************************************************

  logic [7:0] latch_q  [NPORTS];
  logic [7:0] latch_d  [NPORTS];
  logic [7:0] dir_q    [NPORTS];
  logic [7:0] dir_d    [NPORTS];
  logic [7:0] pullup_q [NPORTS];
  logic [7:0] pullup_d [NPORTS];
  logic [7:0] pinOut_q [NPORTS];
  logic [7:0] pinOut_d [NPORTS];
  logic [7:0] pinOe_q  [NPORTS];
  logic [7:0] pinOe_d  [NPORTS];
  logic [7:0] pullOn_q [NPORTS];
  logic [7:0] pullOn_d [NPORTS];

  gpc_pkg::gpc_port_t wrPort;
  gpc_pkg::gpc_kind_t wrKind;

  assign wrPort = decodePort(sfrAddr);
  assign wrKind = decodeKind(sfrAddr);

  // Bit instructions reach us as a full byte write of the CPU's merged value,
  // so only byte writes exist here.
  generate
    for (gp = 0; gp < NPORTS; gp++)
    begin : g_port
      always_comb
      begin
        latch_d[gp]  = latch_q[gp];
        dir_d[gp]    = dir_q[gp];
        pullup_d[gp] = pullup_q[gp];
        if (sfrWrite && wrPort == gpc_pkg::gpc_port_t'(gp))
        begin
          unique case (wrKind)
            // Latch written regardless of direction and kept.
            gpc_pkg::GPC_KIND_DATA:   latch_d[gp]  = sfrWdata & implMask[gp];
            // Unused direction bits stay at one.
            gpc_pkg::GPC_KIND_DIR:    dir_d[gp]    = sfrWdata | ~implMask[gp];
            gpc_pkg::GPC_KIND_PULLUP: pullup_d[gp] = sfrWdata & implMask[gp];
            gpc_pkg::GPC_KIND_NONE:   latch_d[gp]  = latch_q[gp];
          endcase
        end
        // Direction zero enables the buffer, which drives the latch value.
        pinOut_d[gp] = latch_q[gp] & implMask[gp];
        pinOe_d[gp]  = ~dir_q[gp] & implMask[gp];
        // Pull-up only on pins in input mode.
        pullOn_d[gp] = pullup_q[gp] & dir_q[gp] & implMask[gp];
      end

      // Reset leaves every pin in input mode with latches and pull-ups cleared.
      always_ff @(posedge clk_sys or negedge resetn)
      begin
        if (!resetn)
        begin
          latch_q[gp]  <= `GPC_RST_DATA;
          dir_q[gp]    <= `GPC_RST_DIR;
          pullup_q[gp] <= `GPC_RST_PULLUP;
          pinOut_q[gp] <= 8'h00;
          pinOe_q[gp]  <= 8'h00;
          pullOn_q[gp] <= 8'h00;
        end
        else
        begin
          latch_q[gp]  <= latch_d[gp];
          dir_q[gp]    <= dir_d[gp];
          pullup_q[gp] <= pullup_d[gp];
          pinOut_q[gp] <= pinOut_d[gp];
          pinOe_q[gp]  <= pinOe_d[gp];
          pullOn_q[gp] <= pullOn_d[gp];
        end
      end
    end
  endgenerate

  assign port2PinOut       = pinOut_q[0][3:0];
  assign port2PinOe        = pinOe_q[0][3:0];
  assign port2PullupOn     = pullOn_q[0][3:0];
  assign port3Bit2PinOut   = pinOut_q[1][`GPC_PORT3_IO_BIT];
  assign port3Bit2PinOe    = pinOe_q[1][`GPC_PORT3_IO_BIT];
  assign port3Bit2PullupOn = pullOn_q[1][`GPC_PORT3_IO_BIT];
  assign port4PinOut       = pinOut_q[2];
  assign port4PinOe        = pinOe_q[2];
  assign port4PullupOn     = pullOn_q[2];

  // ************************************************************
  // Register read
  // ************************************************************

  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       rvalid_q;
  logic       rvalid_d;
  logic [7:0] portView;
  int         rdIdx;

  always_comb
  begin
    rdata_d  = `GPC_RDATA_UNMAPPED;
    rvalid_d = sfrRead;
    portView = 8'h00;
    rdIdx    = 0;
    if (wrPort != gpc_pkg::GPC_PORT_NONE)
    begin
      rdIdx = int'(wrPort);
      // Input bits show the pin, output bits the latch.
      portView = ((pinSync[rdIdx] & dir_q[rdIdx]) | (latch_q[rdIdx] & ~dir_q[rdIdx])) & implMask[rdIdx];
      // Port 3 bit 4 always shows the pin and has no latch.
      if (wrPort == gpc_pkg::GPC_PORT3)
        portView = portView | (pinSync[1] & `GPC_PORT3_IN_ONLY_MASK);
    end
    if (sfrRead)
    begin
      unique case (wrKind)
        gpc_pkg::GPC_KIND_DATA:   rdata_d = portView;
        gpc_pkg::GPC_KIND_DIR:    rdata_d = dir_q[rdIdx];
        gpc_pkg::GPC_KIND_PULLUP: rdata_d = pullup_q[rdIdx];
        gpc_pkg::GPC_KIND_NONE:   rdata_d = `GPC_RDATA_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign sfrRdata  = rdata_q;
  assign sfrRvalid = rvalid_q;

  // ************************************************************
  // Shared reset pin sequence
  // ************************************************************

  gpc_pkg::gpc_rst_state_t rstState_q;
  gpc_pkg::gpc_rst_state_t rstState_d;
  logic                    portMode_q;
  logic                    portMode_d;
  logic                    hold_q;
  logic                    hold_d;

  // At power-on the pin is a reset input; the option is taken only once it is
  // released, so a low pin before that keeps the chip held.
  always_comb
  begin
    rstState_d = rstState_q;
    portMode_d = portMode_q;
    unique case (rstState_q)
      gpc_pkg::GPC_RST_WAIT_PIN:
      begin
        if (resetPinSync)
          rstState_d = gpc_pkg::GPC_RST_LOAD_OPTION;
      end
      gpc_pkg::GPC_RST_LOAD_OPTION:
      begin
        if (!resetPinSync)
          rstState_d = gpc_pkg::GPC_RST_WAIT_PIN;
        else
        begin
          portMode_d = optionPortSelect;
          rstState_d = gpc_pkg::GPC_RST_RUN;
        end
      end
      gpc_pkg::GPC_RST_RUN:
      begin
        // In port mode the pin can no longer reset the chip.
        if (!portMode_q && !resetPinSync)
          rstState_d = gpc_pkg::GPC_RST_WAIT_PIN;
      end
    endcase
    hold_d = (rstState_d != gpc_pkg::GPC_RST_RUN);
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rstState_q <= gpc_pkg::GPC_RST_WAIT_PIN;
      portMode_q <= 1'b0;
      hold_q     <= 1'b1;
    end
    else
    begin
      rstState_q <= rstState_d;
      portMode_q <= portMode_d;
      hold_q     <= hold_d;
    end
  end

  assign cpuResetHold   = hold_q;
  assign optionPortMode = portMode_q;

  // ************************************************************
  // Interrupt edge sources
  // ************************************************************

  // Edges are taken from the pin itself, so a level the port drives also
  // raises a request; software masks it before using output mode.
  gpc_edge_detect u_edge_p32 (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .level     (pinSync[1][`GPC_PORT3_IO_BIT]),
    .risePulse (port3Bit2IntRise),
    .fallPulse (port3Bit2IntFall)
  );

  gpc_edge_detect u_edge_p21 (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .level     (pinSync[0][`GPC_PORT2_INT_BIT]),
    .risePulse (port2Bit1IntRise),
    .fallPulse (port2Bit1IntFall)
  );

endmodule : gpc_port_ctrl

// ### gpc_pin_model.sv
// Far-side model of the devices wired to a group of port pins.
`timescale 1ns/100ps
module gpc_pin_model #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic [W-1:0] pinOut,
  input  wire logic [W-1:0] pinOe,
  input  wire logic [W-1:0] pullupOn,
  input  wire logic [W-1:0] extVal,
  input  wire logic         extEn,
  output logic      [W-1:0] pinIn
);
  // A floating pin toggles so that no settled value can pass for a real level.
  logic toggle_q = 1'b0;

  always @(posedge clk_sys)
    toggle_q <= ~toggle_q;

  always_comb
  begin
    for (int i = 0; i < W; i++)
      pinIn[i] = pinOe[i] ? pinOut[i] : (extEn ? extVal[i] : (pullupOn[i] ? 1'b1 : toggle_q));
  end
endmodule : gpc_pin_model

// ### gpc_port_ctrl_monitor.sv
// Concurrent checks on the ports of the general-purpose port block.
`timescale 1ns/100ps
module gpc_port_ctrl_monitor (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic [15:0] sfrAddr,
  input wire logic        sfrWrite,
  input wire logic        sfrRead,
  input wire logic [7:0]  sfrWdata,
  input wire logic [7:0]  sfrRdata,
  input wire logic        sfrRvalid,
  input wire logic        optionPortSelect,
  input wire logic [3:0]  port2PinIn,
  input wire logic [3:0]  port2PinOut,
  input wire logic [3:0]  port2PinOe,
  input wire logic [3:0]  port2PullupOn,
  input wire logic        port3Bit2PinIn,
  input wire logic        port3Bit2PinOut,
  input wire logic        port3Bit2PinOe,
  input wire logic        port3Bit2PullupOn,
  input wire logic        port3Bit4InputPin,
  input wire logic [7:0]  port4PinIn,
  input wire logic [7:0]  port4PinOut,
  input wire logic [7:0]  port4PinOe,
  input wire logic [7:0]  port4PullupOn,
  input wire logic        cpuResetHold,
  input wire logic        optionPortMode,
  input wire logic        port3Bit2IntRise,
  input wire logic        port3Bit2IntFall,
  input wire logic        port2Bit1IntRise,
  input wire logic        port2Bit1IntFall
);
  logic mapped;
  logic wDir4;
  logic wLat4;

  assign mapped = sfrAddr inside {16'hff02, 16'hff03, 16'hff04, 16'hff22, 16'hff23, 16'hff24,
                                  16'hff32, 16'hff33, 16'hff34};
  assign wDir4 = sfrWrite && sfrAddr == 16'hff24;
  assign wLat4 = sfrWrite && sfrAddr == 16'hff04;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  property p_idle;
    !sfrRead |=> !sfrRvalid && sfrRdata == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("read data without a read");
  property p_unmap;
    sfrRead && !mapped |=> sfrRvalid && sfrRdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_dir3;
    sfrRead && sfrAddr == 16'hff23 |=> sfrRvalid && sfrRdata[7:3] == 5'h1f && sfrRdata[1:0] == 2'h3;
  endproperty
  a_dir3: assert property (p_dir3) else $error("unused direction bits not one");
  property p_oe4;
    wDir4 ##1 !wDir4 |=> port4PinOe == ~$past(sfrWdata, 2);
  endproperty
  a_oe4: assert property (p_oe4) else $error("port 4 enable does not follow direction");
  property p_out4;
    wLat4 ##1 !wLat4 |=> (port4PinOut & port4PinOe) == ($past(sfrWdata, 2) & port4PinOe);
  endproperty
  a_out4: assert property (p_out4) else $error("port 4 driven level wrong");
  property p_pull;
    !(port3Bit2PullupOn && port3Bit2PinOe) && (port4PullupOn & port4PinOe) == 8'h00;
  endproperty
  a_pull: assert property (p_pull) else $error("pull-up on a driven pin");
  property p_hold;
    (!port3Bit4InputPin && !optionPortMode) [*4] |=> cpuResetHold;
  endproperty
  a_hold: assert property (p_hold) else $error("low reset pin not holding");
  property p_opt;
    $changed(optionPortMode) |-> $fell(cpuResetHold);
  endproperty
  a_opt: assert property (p_opt) else $error("option changed outside reset exit");
  property p_int;
    $rose(port3Bit2PinIn) |-> ##[2:4] port3Bit2IntRise;
  endproperty
  a_int: assert property (p_int) else $error("pin rise gave no request");

  c_read: cover property (sfrRead && mapped);
  c_exit: cover property ($fell(cpuResetHold));
  c_int: cover property (port3Bit2IntRise);
endmodule : gpc_port_ctrl_monitor

bind gpc_port_ctrl gpc_port_ctrl_monitor i_mon (.*);

// ### tb_general_purpose_port_control.sv
// Self-checking testbench of the general-purpose port block.
`timescale 1ns/100ps
module tb_general_purpose_port_control;
  localparam int IMPL [3] = '{32'h0f, 32'h04, 32'hff};
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] sfrAddr = 16'h0000;
  logic sfrWrite = 1'b0;
  logic sfrRead = 1'b0;
  logic [7:0] sfrWdata = 8'h00;
  logic optionPortSelect = 1'b0;
  logic port3Bit4InputPin = 1'b0;
  logic [7:0] sfrRdata, port4PinIn, port4PinOut, port4PinOe, port4PullupOn;
  logic [3:0] port2PinIn, port2PinOut, port2PinOe, port2PullupOn;
  logic sfrRvalid, port3Bit2PinIn, port3Bit2PinOut, port3Bit2PinOe, port3Bit2PullupOn, cpuResetHold;
  logic optionPortMode, port3Bit2IntRise, port3Bit2IntFall, port2Bit1IntRise, port2Bit1IntFall;
  logic [3:0] ext2 = 4'h0;
  logic [7:0] ext4 = 8'h00;
  logic ext3 = 1'b0;
  logic en2 = 1'b1;
  logic en3 = 1'b1;
  logic en4 = 1'b1;
  logic [31:0] rng;
  int dirM [3];
  int latM [3];
  int puM [3];
  int mismatches = 0;
  int samples_checked = 0;

  always #2 clk_sys = ~clk_sys;

  gpc_port_ctrl i_dut (.*);
  gpc_pin_model #(.W(4)) i_p2 (.clk_sys(clk_sys), .pinOut(port2PinOut), .pinOe(port2PinOe),
    .pullupOn(port2PullupOn), .extVal(ext2), .extEn(en2), .pinIn(port2PinIn));
  gpc_pin_model #(.W(1)) i_p3 (.clk_sys(clk_sys), .pinOut(port3Bit2PinOut), .pinOe(port3Bit2PinOe),
    .pullupOn(port3Bit2PullupOn), .extVal(ext3), .extEn(en3), .pinIn(port3Bit2PinIn));
  gpc_pin_model #(.W(8)) i_p4 (.clk_sys(clk_sys), .pinOut(port4PinOut), .pinOe(port4PinOe),
    .pullupOn(port4PullupOn), .extVal(ext4), .extEn(en4), .pinIn(port4PinIn));

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  function automatic logic [15:0] adr(input int p, input int k);
    return 16'hff02 + 16'(p) + (k == 0 ? 16'h0000 : (k == 1 ? 16'h0020 : 16'h0030));
  endfunction : adr

  function automatic int expRd(input int p, input int k);
    int pin;
    if (k == 1)
      return dirM[p];
    if (k == 2)
      return puM[p];
    case (p)
      0: pin = en2 ? int'(ext2) : puM[0];
      1: pin = en3 ? int'(ext3) << 2 : puM[1];
      default: pin = en4 ? int'(ext4) : puM[2];
    endcase
    return (((pin & dirM[p]) | (latM[p] & ~dirM[p])) & IMPL[p]) | (p == 1 ? int'(port3Bit4InputPin) << 4 : 0);
  endfunction : expRd

  task automatic summarize;
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic waitBit(input int which, input logic v);
    int n;
    logic s;
    for (n = 0; n < 20; n++)
    begin
      @(negedge clk_sys);
      s = which == 0 ? cpuResetHold : (which == 1 ? port3Bit2IntRise : port3Bit2IntFall);
      if (which > 2)
        s = which == 3 ? port2Bit1IntRise : port2Bit1IntFall;
      if (s === v)
        break;
    end
    samples_checked++;
    if (n == 20)
    begin
      mismatches++;
      summarize();
    end
  endtask : waitBit

  task automatic wr(input int p, input int k, input logic [7:0] d);
    @(negedge clk_sys);
    sfrAddr = adr(p, k);
    sfrWdata = d;
    sfrWrite = 1'b1;
    @(negedge clk_sys);
    sfrWrite = 1'b0;
    if (k == 1)
      dirM[p] = (int'(d) | ~IMPL[p]) & 'hff;
    else if (k == 0)
      latM[p] = int'(d) & IMPL[p];
    else
      puM[p] = int'(d) & IMPL[p];
  endtask : wr

  task automatic rd(input logic [15:0] a, input int e);
    @(negedge clk_sys);
    sfrAddr = a;
    sfrRead = 1'b1;
    @(negedge clk_sys);
    sfrRead = 1'b0;
    check({sfrRvalid, sfrRdata}, 'h100 | e);
  endtask : rd

  task automatic readAll;
    for (int p = 0; p < 3; p++)
      for (int k = 0; k < 3; k++)
        rd(adr(p, k), expRd(p, k));
    check(port4PinOe, ~dirM[2] & 'hff);
    check(port4PinOut & port4PinOe, latM[2] & ~dirM[2] & 'hff);
    check(port4PullupOn, puM[2] & dirM[2]);
    check({port3Bit2PinOe, port3Bit2PullupOn}, {~dirM[1][2], puM[1][2] & dirM[1][2]});
    check(port2PinOe, ~dirM[0] & 'h0f);
    check(port2PinOut & port2PinOe, latM[0] & ~dirM[0] & 'h0f);
    check(port2PullupOn, puM[0] & dirM[0] & 'h0f);
    check(port3Bit2PinOut, latM[1][2]);
  endtask : readAll

  task automatic startUp(input logic opt);
    resetn = 1'b0;
    port3Bit4InputPin = 1'b0;
    optionPortSelect = opt;
    dirM = '{255, 255, 255};
    latM = '{0, 0, 0};
    puM = '{0, 0, 0};
    repeat (12) @(negedge clk_sys);
    resetn = 1'b1;
    for (int n = 0; n < 8; n++)
    begin
      @(negedge clk_sys);
      check({port3Bit2IntRise, port2Bit1IntRise}, 0);
    end
    check(cpuResetHold, 1);
    port3Bit4InputPin = 1'b1;
    waitBit(0, 1'b0);
    check(optionPortMode, opt);
  endtask : startUp

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    rng = 32'h1e34;
    startUp(1'b0);
    readAll();
    rd(16'hff05, 0);
    repeat (30)
    begin
      rng = xs(rng);
      ext2 = rng[3:0];
      ext3 = rng[4];
      ext4 = rng[15:8];
      wr(rng[17:16] % 3, rng[19:18] % 3, rng[31:24]);
      repeat (4) @(negedge clk_sys);
      readAll();
    end
    wr(2, 1, 8'hff);
    wr(2, 2, 8'hff);
    en4 = 1'b0;
    repeat (4) @(negedge clk_sys);
    rd(adr(2, 0), 'hff);
    en4 = 1'b1;
    wr(1, 0, 8'h00);
    wr(1, 1, 8'hfb);
    wr(1, 0, 8'h04);
    waitBit(1, 1'b1);
    wr(1, 0, 8'h00);
    waitBit(2, 1'b1);
    wr(0, 0, 8'h00);
    wr(0, 1, 8'hfd);
    wr(0, 0, 8'h02);
    waitBit(3, 1'b1);
    wr(0, 0, 8'h00);
    waitBit(4, 1'b1);
    port3Bit4InputPin = 1'b0;
    waitBit(0, 1'b1);
    port3Bit4InputPin = 1'b1;
    waitBit(0, 1'b0);
    ext2 = 4'hf;
    ext3 = 1'b1;
    startUp(1'b1);
    port3Bit4InputPin = 1'b0;
    repeat (6) @(negedge clk_sys);
    check(cpuResetHold, 0);
    rd(adr(1, 0), expRd(1, 0));
    summarize();
  end
endmodule : tb_general_purpose_port_control
